//--- hdl/fenb_pkg.sv
// Package: constants and carrier types for the fault enable and user storage bank
package fenb_pkg;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam logic [7:0] PAGE_SEL_OFFSET   = 8'h7F;
  localparam logic [7:0] USER_FIRST_OFFSET = 8'h80;
  localparam logic [7:0] USER_LAST_OFFSET  = 8'hF7;
  localparam logic [7:0] TS_ALARM_OFFSET   = 8'hF8;
  localparam logic [7:0] SS_ALARM_OFFSET   = 8'hF9;
  localparam logic [7:0] RSVD_FA_OFFSET    = 8'hFA;
  localparam logic [7:0] SL_ALARM_OFFSET   = 8'hFB;
  localparam logic [7:0] TS_WARN_OFFSET    = 8'hFC;
  localparam int         USER_DEPTH        = 120;
  localparam logic [7:0] STORAGE_PAGE      = 8'h01;
  localparam logic [7:0] ENABLE_ALT_PAGE   = 8'h05;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int         TS_FIELD_LSB   = 4;
  localparam int         RX_FIELD_LSB   = 6;
  localparam logic [7:0] ENABLE_RESET   = 8'h00;
  localparam logic [7:0] USER_RESET     = 8'h00;
  localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
  localparam logic [7:0] READ_FILL      = 8'h00;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic lower_password_level;
    logic upper_password_level;
    logic storage_rw_grant;
    logic storage_read_grant;
    logic enable_rw_grant;
    logic enable_read_grant;
  } fenb_access_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       rcvr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fenb_req_t;

  // Order matches enable bits 7..4
  typedef struct packed {
    logic temperature_high_flag;
    logic temperature_low_flag;
    logic supply_high_flag;
    logic supply_low_flag;
  } fenb_ts_flags_t;

  // Strength flags match bits 7..6 of one enable, compare flags of the other
  typedef struct packed {
    logic strength_high_flag;
    logic strength_low_flag;
    logic fast_high_compare_flag;
    logic fast_low_compare_flag;
  } fenb_rx_flags_t;

  typedef struct packed {
    logic       start;
    logic       rcvr;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] data;
  } fenb_nv_t;

endpackage : fenb_pkg

//--- hdl/fenb_bank.sv
// Fault enable registers, user nonvolatile bytes and page selectors
`timescale 1ns/1ps

module fenb_bank (
  // Clock and reset
  input  wire logic                      i_mclk,
  input  wire logic                      i_rst,
  // Register access from the serial core
  input  wire fenb_pkg::fenb_req_t       i_req,
  input  wire fenb_pkg::fenb_access_t    i_access,
  // Configuration
  input  wire logic                      i_enable_page_alt,
  input  wire logic                      i_shadow_write_block,
  // Monitor flags
  input  wire fenb_pkg::fenb_ts_flags_t  i_alarm_flags,
  input  wire fenb_pkg::fenb_ts_flags_t  i_warn_flags,
  input  wire fenb_pkg::fenb_rx_flags_t  i_rx_flags [2],
  // Answers
  output logic                           o_rd_valid,
  output logic [7:0]                     o_rd_data,
  output logic                           o_denied,
  output fenb_pkg::fenb_nv_t             o_nv_write,
  output logic [7:0]                     o_page_sel [2],
  output logic                           o_fault_interrupt_out
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] user_mem_ff [fenb_pkg::USER_DEPTH];
  logic [3:0] ts_alarm_en_ff;
  logic [3:0] ts_warn_en_ff;
  logic [1:0] ss_alarm_en_ff [2];
  logic [1:0] sl_alarm_en_ff [2];
  logic [7:0] page_sel_ff    [2];
  logic       rd_valid_ff;
  logic [7:0] rd_data_ff;
  logic       denied_ff;
  logic       fault_ff;
  fenb_pkg::fenb_nv_t nv_ff;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire        rx          = i_req.rcvr;
  wire [7:0]  cur_page    = page_sel_ff[rx];
  wire [7:0]  en_page     = i_enable_page_alt ? fenb_pkg::ENABLE_ALT_PAGE
                                              : fenb_pkg::STORAGE_PAGE;
  wire        hit_psel    = i_req.addr == fenb_pkg::PAGE_SEL_OFFSET;
  wire        hit_user    = (cur_page == fenb_pkg::STORAGE_PAGE)
                            && (i_req.addr >= fenb_pkg::USER_FIRST_OFFSET)
                            && (i_req.addr <= fenb_pkg::USER_LAST_OFFSET);
  wire        in_en_page  = cur_page == en_page;
  wire        hit_ts_al   = in_en_page && (i_req.addr == fenb_pkg::TS_ALARM_OFFSET);
  wire        hit_ss_al   = in_en_page && (i_req.addr == fenb_pkg::SS_ALARM_OFFSET);
  wire        hit_sl_al   = in_en_page && (i_req.addr == fenb_pkg::SL_ALARM_OFFSET);
  wire        hit_ts_wn   = in_en_page && (i_req.addr == fenb_pkg::TS_WARN_OFFSET);
  wire        hit_enable  = hit_ts_al || hit_ss_al || hit_sl_al || hit_ts_wn;
  wire [6:0]  user_idx    = 7'(i_req.addr - fenb_pkg::USER_FIRST_OFFSET);

  // ****************************************************************
  // Password checks
  // ****************************************************************
  wire user_rd_ok = i_access.upper_password_level
                    || (i_access.lower_password_level
                        && (i_access.storage_rw_grant || i_access.storage_read_grant));
  wire user_wr_ok = i_access.upper_password_level
                    || (i_access.lower_password_level && i_access.storage_rw_grant);
  wire en_rd_ok   = i_access.upper_password_level
                    || (i_access.lower_password_level
                        && (i_access.enable_rw_grant || i_access.enable_read_grant));
  wire en_wr_ok   = i_access.upper_password_level
                    || (i_access.lower_password_level && i_access.enable_rw_grant);

  wire rd_req   = i_req.valid && !i_req.write;
  wire wr_req   = i_req.valid && i_req.write;
  wire rd_deny  = rd_req && ((hit_user && !user_rd_ok) || (hit_enable && !en_rd_ok));
  wire wr_deny  = wr_req && ((hit_user && !user_wr_ok) || (hit_enable && !en_wr_ok));
  wire wr_user  = wr_req && hit_user && user_wr_ok;
  wire wr_en    = wr_req && hit_enable && en_wr_ok;
  wire wr_psel  = wr_req && hit_psel;

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Reserved bits are not stored, so they always read back as zero
  wire [7:0] rd_ts_al = {ts_alarm_en_ff, 4'h0};
  wire [7:0] rd_ts_wn = {ts_warn_en_ff, 4'h0};
  wire [7:0] rd_ss_al = {ss_alarm_en_ff[rx], 6'h00};
  wire [7:0] rd_sl_al = {sl_alarm_en_ff[rx], 6'h00};
  wire [7:0] rd_mux   = hit_psel  ? cur_page :
                        hit_user  ? user_mem_ff[user_idx] :
                        hit_ts_al ? rd_ts_al :
                        hit_ss_al ? rd_ss_al :
                        hit_sl_al ? rd_sl_al :
                        hit_ts_wn ? rd_ts_wn : fenb_pkg::READ_FILL;
  wire [7:0] nxt_rd_data = rd_deny ? fenb_pkg::READ_FILL : rd_mux;

  // ****************************************************************
  // Nonvolatile write request
  // ****************************************************************
  // Shadowed enables may skip the slow EE cycle; user bytes never do
  wire nxt_nv_start = wr_user || (wr_en && !i_shadow_write_block);

  // ****************************************************************
  // Fault gating
  // ****************************************************************
  wire [1:0] rx_fault;
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_rx
      wire [1:0] ss_f = {i_rx_flags[g].strength_high_flag, i_rx_flags[g].strength_low_flag};
      wire [1:0] sl_f = {i_rx_flags[g].fast_high_compare_flag, i_rx_flags[g].fast_low_compare_flag};
      assign rx_fault[g] = |(ss_f & ss_alarm_en_ff[g]) || |(sl_f & sl_alarm_en_ff[g]);
    end
  endgenerate
  wire nxt_fault = |(i_alarm_flags & ts_alarm_en_ff)
                   || |(i_warn_flags & ts_warn_en_ff)
                   || |rx_fault;

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ts_alarm_en_ff <= fenb_pkg::ENABLE_RESET[7:4];
      ts_warn_en_ff  <= fenb_pkg::ENABLE_RESET[7:4];
    end
    else if (wr_en && hit_ts_al)
      ts_alarm_en_ff <= i_req.wdata[7:fenb_pkg::TS_FIELD_LSB];
    else if (wr_en && hit_ts_wn)
      ts_warn_en_ff  <= i_req.wdata[7:fenb_pkg::TS_FIELD_LSB];
  end

  generate
    for (g = 0; g < 2; g++)
    begin : g_rx_regs
      always_ff @(posedge i_mclk or posedge i_rst)
      begin
        if (i_rst)
        begin
          ss_alarm_en_ff[g] <= fenb_pkg::ENABLE_RESET[7:6];
          sl_alarm_en_ff[g] <= fenb_pkg::ENABLE_RESET[7:6];
          page_sel_ff[g]    <= fenb_pkg::PAGE_SEL_RESET;
        end
        else if (rx == 1'(g))
        begin
          if (wr_en && hit_ss_al)
            ss_alarm_en_ff[g] <= i_req.wdata[7:fenb_pkg::RX_FIELD_LSB];
          if (wr_en && hit_sl_al)
            sl_alarm_en_ff[g] <= i_req.wdata[7:fenb_pkg::RX_FIELD_LSB];
          if (wr_psel)
            page_sel_ff[g] <= i_req.wdata;
        end
      end
    end
    for (g = 0; g < fenb_pkg::USER_DEPTH; g++)
    begin : g_user
      always_ff @(posedge i_mclk or posedge i_rst)
      begin
        if (i_rst)
          user_mem_ff[g] <= fenb_pkg::USER_RESET;
        else if (wr_user && (user_idx == 7'(g)))
          user_mem_ff[g] <= i_req.wdata;
      end
    end
  endgenerate

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= fenb_pkg::READ_FILL;
      denied_ff   <= 1'b0;
      fault_ff    <= 1'b0;
      nv_ff       <= '0;
    end
    else
    begin
      rd_valid_ff <= rd_req;
      rd_data_ff  <= rd_req ? nxt_rd_data : rd_data_ff;
      denied_ff   <= rd_deny || wr_deny;
      fault_ff    <= nxt_fault;
      nv_ff.start <= nxt_nv_start;
      if (nxt_nv_start)
      begin
        nv_ff.rcvr <= rx;
        nv_ff.page <= cur_page;
        nv_ff.addr <= i_req.addr;
        nv_ff.data <= i_req.wdata;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_rd_valid            = rd_valid_ff;
  assign o_rd_data             = rd_data_ff;
  assign o_denied              = denied_ff;
  assign o_nv_write            = nv_ff;
  assign o_page_sel            = page_sel_ff;
  assign o_fault_interrupt_out = fault_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_user_write_back: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_user |=> (user_mem_ff[$past(user_idx)] == $past(i_req.wdata)))
    else $error("user byte did not store written data");
  a_user_rd_deny: assert property (@(posedge i_mclk) disable iff (i_rst)
    (rd_req && hit_user && !i_access.upper_password_level && !i_access.lower_password_level)
    |=> (o_denied && o_rd_valid && o_rd_data == 8'h00))
    else $error("storage read without password not refused");
  a_enable_wr_deny: assert property (@(posedge i_mclk) disable iff (i_rst)
    (wr_req && hit_ts_al && !i_access.upper_password_level && !i_access.enable_rw_grant)
    |=> ($stable(ts_alarm_en_ff) && o_denied))
    else $error("enable write without grant took effect");
  a_shared_alarm_en: assert property (@(posedge i_mclk) disable iff (i_rst)
    (rd_req && hit_ts_al && en_rd_ok) |=> (o_rd_data == {ts_alarm_en_ff, 4'h0}))
    else $error("shared alarm enable read mismatch");
  a_per_rx_copy: assert property (@(posedge i_mclk) disable iff (i_rst)
    (wr_en && hit_ss_al) |=> (ss_alarm_en_ff[!$past(i_req.rcvr)] == $past(ss_alarm_en_ff[!i_req.rcvr])))
    else $error("other receiver enable copy changed");
  a_ts_gate: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_alarm_flags.temperature_high_flag && ts_alarm_en_ff[3]) |=> o_fault_interrupt_out)
    else $error("enabled temperature alarm did not raise fault");
  a_reserved_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
    (rd_req && (hit_ss_al || hit_sl_al)) |=> (o_rd_data[5:0] == 6'h00))
    else $error("reserved enable bits read non-zero");
  a_fault_blocked: assert property (@(posedge i_mclk) disable iff (i_rst)
    (ts_alarm_en_ff == 4'h0 && ts_warn_en_ff == 4'h0 && ss_alarm_en_ff[0] == 2'b00
     && ss_alarm_en_ff[1] == 2'b00 && sl_alarm_en_ff[0] == 2'b00 && sl_alarm_en_ff[1] == 2'b00)
    |=> !o_fault_interrupt_out)
    else $error("fault raised with all enables clear");
  a_page_map: assert property (@(posedge i_mclk) disable iff (i_rst)
    (rd_req && i_req.addr == fenb_pkg::TS_WARN_OFFSET && cur_page != en_page)
    |=> (o_rd_data == 8'h00))
    else $error("enable seen outside its selected page");
  a_page_select: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_psel |=> (o_page_sel[$past(i_req.rcvr)] == $past(i_req.wdata)))
    else $error("page selector not updated");
  a_shadow_block: assert property (@(posedge i_mclk) disable iff (i_rst)
    (wr_en && i_shadow_write_block) |=> !o_nv_write.start)
    else $error("nonvolatile write started under shadow block");

  // ****************************************************************
  // Checks on gating, grants and reset
  // ****************************************************************
  a_user_wr_deny: assert property (@(posedge i_mclk) disable iff (i_rst)
    (wr_req && hit_user && !i_access.upper_password_level && !i_access.storage_rw_grant)
    |=> (o_denied && !o_nv_write.start))
    else $error("storage write without grant not refused");
  a_enable_rd_grant: assert property (@(posedge i_mclk) disable iff (i_rst)
    (rd_req && hit_enable && i_access.lower_password_level && i_access.enable_read_grant)
    |=> (o_rd_valid && !o_denied))
    else $error("enable read with read grant refused");
  a_shared_warn_en: assert property (@(posedge i_mclk) disable iff (i_rst)
    (wr_en && hit_ts_wn) |=> (ts_warn_en_ff == $past(i_req.wdata[7:4])))
    else $error("shared warning enable not written from either receiver");
  a_per_rx_loss: assert property (@(posedge i_mclk) disable iff (i_rst)
    (wr_en && hit_sl_al) |=> (sl_alarm_en_ff[!$past(i_req.rcvr)] == $past(sl_alarm_en_ff[!i_req.rcvr])))
    else $error("other receiver loss enable copy changed");
  a_strength_gate: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_rx_flags[1].strength_low_flag && ss_alarm_en_ff[1][0]) |=> o_fault_interrupt_out)
    else $error("enabled strength alarm did not raise fault");
  a_loss_gate: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_rx_flags[0].fast_high_compare_flag && sl_alarm_en_ff[0][1]) |=> o_fault_interrupt_out)
    else $error("enabled loss alarm did not raise fault");
  a_warn_gate: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_warn_flags.supply_low_flag && ts_warn_en_ff[0]) |=> o_fault_interrupt_out)
    else $error("enabled supply warning did not raise fault");
  a_fault_source: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(o_fault_interrupt_out) |-> $past(i_alarm_flags != 4'h0 || i_warn_flags != 4'h0
    || i_rx_flags[0] != 4'h0 || i_rx_flags[1] != 4'h0))
    else $error("fault raised with no flag set");
  a_enable_write_page: assert property (@(posedge i_mclk) disable iff (i_rst)
    (wr_req && i_req.addr == fenb_pkg::TS_ALARM_OFFSET && cur_page != en_page) |=> $stable(ts_alarm_en_ff))
    else $error("enable written outside its selected page");
  a_page_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
    !wr_psel |=> ($stable(o_page_sel[0]) && $stable(o_page_sel[1])))
    else $error("page selector changed without a write");
  a_nv_user_start: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_user |=> (o_nv_write.start && o_nv_write.addr == $past(i_req.addr)))
    else $error("user byte write did not start nonvolatile cycle");
  a_reset_state: assert property (@(posedge i_mclk) disable iff (i_rst)
    $fell(i_rst) |-> (ts_alarm_en_ff == fenb_pkg::ENABLE_RESET[7:4] && o_page_sel[0] == fenb_pkg::PAGE_SEL_RESET
    && o_page_sel[1] == fenb_pkg::PAGE_SEL_RESET && !o_fault_interrupt_out))
    else $error("power-on state not restored");

endmodule : fenb_bank

//--- tb/fenb_host.sv
// Host model driving single register accesses into the bank
`timescale 1ns/1ps
module fenb_host (
  // Clock
  input  wire logic               i_mclk,
  // Request side
  output fenb_pkg::fenb_req_t     o_req,
  output fenb_pkg::fenb_access_t  o_access
);
  initial
  begin
    o_req    = '0;
    o_access = '0;
  end

  // ****************************************************************
  // One access: raised at a falling edge, taken at the next rise
  // ****************************************************************
  task automatic access(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
                        input logic [5:0] acc);
    @(negedge i_mclk);
    o_access = acc;
    o_req    = '{valid: 1'b1, write: w, rcvr: r, addr: a, wdata: d};
    @(negedge i_mclk);
    o_req.valid = 1'b0;
    // Stale data inverted so a late sample cannot pass by luck
    o_req.wdata = ~d;
  endtask : access
endmodule : fenb_host

//--- tb/fenb_bank_test.sv
// Self-checking bench for the fault enable and user storage bank
`timescale 1ns/1ps
module fenb_bank_test;
  logic                     i_mclk, i_rst, alt, shadow_write_block, rd_valid, denied, fault;
  logic [7:0]               rd_data, a, d;
  logic [7:0]               page_sel [2];
  logic [7:0]               probe [7] = '{8'h80, 8'hF7, 8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC};
  fenb_pkg::fenb_req_t      req;
  fenb_pkg::fenb_access_t   acc;
  fenb_pkg::fenb_ts_flags_t alarm, warn;
  fenb_pkg::fenb_rx_flags_t rx [2];
  fenb_pkg::fenb_nv_t       nv;
  int                       error_cnt, samples_checked, ts_en, wn_en;
  int                       user [120];
  int                       pg [2], ss_en [2], sl_en [2];

  fenb_host host (.i_mclk(i_mclk), .o_req(req), .o_access(acc));
  fenb_bank uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_req(req), .i_access(acc), .i_enable_page_alt(alt),
    .i_shadow_write_block(shadow_write_block), .i_alarm_flags(alarm), .i_warn_flags(warn), .i_rx_flags(rx),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_denied(denied), .o_nv_write(nv),
    .o_page_sel(page_sel), .o_fault_interrupt_out(fault));

  // ****************************************************************
  // Model and comparison
  // ****************************************************************
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d, input logic [5:0] p);
    int i, xd, den, nvs, ok, usr, enr;
    i = a - 8'h80;
    usr = pg[r] == 1 && a >= 8'h80 && a <= 8'hF7;
    enr = pg[r] == (alt ? 5 : 1) && (a == 8'hF8 || a == 8'hF9 || a == 8'hFB || a == 8'hFC);
    ok = p[4] | p[5] & (usr ? p[3] | !w & p[2] : p[1] | !w & p[0]);
    den = (usr || enr) && !ok;
    xd = 0;
    nvs = 0;
    if (a == 8'h7F)
      if (w) pg[r] = d; else xd = pg[r];
    else if (usr && ok)
    begin
      if (w) user[i] = d; else xd = user[i];
      nvs = w;
    end
    else if (enr && ok)
    begin
      // Only documented enable bits are kept
      if (w) case (a)
        8'hF8: ts_en = d & 8'hF0;
        8'hF9: ss_en[r] = d & 8'hC0;
        8'hFB: sl_en[r] = d & 8'hC0;
        default: wn_en = d & 8'hF0;
      endcase
      xd = a == 8'hF8 ? ts_en : a == 8'hF9 ? ss_en[r] : a == 8'hFB ? sl_en[r] : wn_en;
      nvs = w && !shadow_write_block;
    end
    host.access(w, r, a, d, p);
    check("denied", den[7:0], {7'h0, denied}); // Password gating
    check("nv start", nvs[7:0], {7'h0, nv.start}); // Shadow block
    if (nvs) check("nv addr", a, nv.addr); // Storage target
    if (nvs) check("nv data", d, nv.data); // Storage data
    if (nvs) check("nv page", pg[r][7:0], nv.page); // Storage page
    if (nvs) check("nv rcvr", {7'h0, r}, {7'h0, nv.rcvr}); // Receiver copy
    if (!w) check("read data", xd[7:0], rd_data); // Shared and split copies
    check("read valid", {7'h0, !w}, {7'h0, rd_valid}); // Read answer
    for (int k = 0; k < 2; k++) check("page sel", pg[k][7:0], page_sel[k]); // Page selectors
  endtask : op

  task automatic fault_chk();
    int e;
    alarm = 4'($urandom);
    warn = 4'($urandom);
    rx[0] = 4'($urandom);
    rx[1] = 4'($urandom);
    @(negedge i_mclk);
    e = |(alarm & ts_en[7:4]) | |(warn & wn_en[7:4]);
    for (int r = 0; r < 2; r++) e = e | |(rx[r][3:2] & ss_en[r][7:6]) | |(rx[r][1:0] & sl_en[r][7:6]);
    check("fault", e[7:0], {7'h0, fault}); // Flag gating
  endtask : fault_chk

  task automatic reset_probe();
    i_rst = 1;
    foreach (user[k]) user[k] = 0;
    ts_en = 0;
    wn_en = 0;
    pg = '{0, 0};
    ss_en = '{0, 0};
    sl_en = '{0, 0};
    repeat (2) @(negedge i_mclk);
    i_rst = 0;
    for (int r = 0; r < 2; r++)
    begin
      // Page 00h maps only the page selector of this bank
      op(0, r[0], 8'h80, 0, 6'h10); // Power-on state
      op(1, r[0], 8'h7F, 8'h01, 6'h00); // Page select
      foreach (probe[k]) op(0, r[0], probe[k], 0, 6'h10); // Power-on state
    end
    fault_chk(); // Enables cleared by reset
    $display("test reset_probe done");
  endtask : reset_probe

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // ****************************************************************
  // Clock, watchdog and test sequence
  // ****************************************************************
  initial
  begin
    i_mclk = 0;
    forever #2 i_mclk = ~i_mclk;
  end

  initial
  begin
    #200000;
    error_cnt++;
    conclude();
  end

  initial
  begin
    {alt, shadow_write_block, alarm, warn} = '0;
    rx = '{default: '0};
    error_cnt = 0;
    samples_checked = 0;
    void'($urandom(32'h2ff0));
    reset_probe();
    for (int n = 0; n < 3000; n++)
    begin
      shadow_write_block = 1'($urandom);
      if (n % 500 == 0) alt = ~alt;
      a = $urandom_range(0, 3) == 0 ? probe[$urandom_range(0, 6)] : 8'($urandom_range(8'h7E, 8'hFF));
      if ($urandom_range(0, 15) == 0) a = 8'h7F;
      d = 8'($urandom);
      if (a == 8'h7F) d = $urandom_range(0, 1) ? 8'h05 : 8'h01;
      op(1'($urandom), 1'($urandom), a, d, 6'($urandom)); // Mixed traffic
      fault_chk(); // Fault gating
    end
    $display("test random_traffic done");
    // Second reset after the random traffic must restore the power-on state
    reset_probe(); // Power-on state
    conclude();
  end
endmodule : fenb_bank_test
